/* shared/lsma_pkg.sv */
// Shared types, constants and lane helpers of the load/store access unit
package lsma_pkg;

  // ==========================================================================
  // Widths and address layout
  // ==========================================================================
  localparam int          LSMA_DW       = 32;
  localparam int          LSMA_IMM_W    = 16;
  localparam int          LSMA_FULL_AW  = 32;
  localparam int          LSMA_BYP_AW   = 31;
  localparam int          LSMA_BYP_BIT  = 31;
  localparam int          LSMA_LANE_W   = 2;
  localparam int          LSMA_BE_W     = 4;
  localparam logic [1:0]  LSMA_LANE0    = 2'h0;
  localparam logic [1:0]  LSMA_LANE2    = 2'h2;
  localparam logic [3:0]  LSMA_BE_BYTE  = 4'h1;
  localparam logic [3:0]  LSMA_BE_HALF  = 4'h3;
  localparam logic [3:0]  LSMA_BE_WORD  = 4'hF;
  localparam logic [31:0] LSMA_ZERO     = 32'h0000_0000;

  // ==========================================================================
  // Operation encodings
  // ==========================================================================
  typedef enum logic [1:0] {LSMA_SZ_BYTE, LSMA_SZ_HALF, LSMA_SZ_WORD} lsma_size_t;

  typedef enum logic [1:0] {
    LSMA_CMO_NONE,
    LSMA_CMO_INIT_LINE,
    LSMA_CMO_FLUSH_LINE,
    LSMA_CMO_FLUSH_ALL
  } lsma_cmo_t;

  typedef struct packed {
    logic       store;
    logic       io;
    logic       uns;
    lsma_size_t size;
    lsma_cmo_t  cmo;
  } lsma_op_t;

  typedef enum {LSMA_ST_IDLE, LSMA_ST_LOOK, LSMA_ST_BUS} lsma_state_t;

  // ==========================================================================
  // Lane helpers
  // ==========================================================================
  function automatic logic [3:0] lsma_be(input lsma_size_t sz, input logic [1:0] lane);
    unique case (sz)
      LSMA_SZ_BYTE: lsma_be = LSMA_BE_BYTE << lane;
      LSMA_SZ_HALF: lsma_be = LSMA_BE_HALF << {lane[1], 1'b0};
      default:      lsma_be = LSMA_BE_WORD;
    endcase
  endfunction : lsma_be

  function automatic logic [31:0] lsma_ext(input lsma_size_t sz, input logic uns,
                                           input logic [1:0] lane, input logic [31:0] w);
    logic [31:0] sh;
    sh = w >> {lane, 3'h0};
    unique case (sz)
      LSMA_SZ_BYTE: lsma_ext = uns ? {24'h000000, sh[7:0]} : {{24{sh[7]}}, sh[7:0]};
      LSMA_SZ_HALF: lsma_ext = uns ? {16'h0000, sh[15:0]} : {{16{sh[15]}}, sh[15:0]};
      default:      lsma_ext = w;
    endcase
  endfunction : lsma_ext

endpackage : lsma_pkg

/* hdl/lsma_line_ram.sv */
// Line store of the data cache, one word plus tag per line, registered read
`timescale 1ns/1ps
module lsma_line_ram #(
  parameter int W     = 64,
  parameter int IDX_W = 4
) (
  // Clock
  input  wire logic             mclk,
  input  wire logic             ce,
  // Write port
  input  wire logic             we,
  input  wire logic [IDX_W-1:0] waddr,
  input  wire logic [W-1:0]     wdata,
  // Read port
  input  wire logic             re,
  input  wire logic [IDX_W-1:0] raddr,
  output logic      [W-1:0]     rdata
);
  logic [W-1:0] mem [2**IDX_W];

  always_ff @(posedge mclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : lsma_line_ram

/* hdl/lsma_unit.sv */
// Load/store access unit: address forming, lane steering, cache and uncached path
`timescale 1ns/1ps

// Contract
// R1: Byte addresses up to 32 bits wide.
// R2: Narrower address width leaves upper bits undriven. The unit masks them with AMASK and drives them as zero.
// R3: One shared address space for everything.
// R4: Unmapped addresses give undefined results.
// R5: Data bus is 32 bits wide.
// R6: Byte, half-word and word transfers supported.
// R7: Little-endian, higher bytes at higher addresses.
// R8: Address is register plus signed immediate.
// R9: Bit-31 bypass: 2 GB, top bit uncaches.
// R10: Without cache, cache ops do nothing.
// R11: Cached accesses may be cached or suppressed.
// R12: Peripheral accesses in order, never suppressed.
// R13: Signed narrow loads sign-extend to 32.
// R14: Unsigned narrow loads zero-extend to 32.
// R15: Narrow stores write only low part.
// R16: Narrow peripheral accesses bypass cache.
// R17: Cache init, flush and bypass offered.
module lsma_unit #(
  parameter int ADDR_W    = 32,
  parameter bit HAS_CACHE = 1'b1,
  parameter bit BYPASS31  = 1'b0,
  parameter int IDX_W     = 4
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  // Request from the core
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire lsma_pkg::lsma_op_t       req_op,
  input  wire logic [31:0]              req_base,
  input  wire logic [15:0]              req_imm,
  input  wire logic [31:0]              req_wdata,
  // Load answer
  output logic                          resp_valid,
  output logic [31:0]                   resp_data,
  // Data bus
  output logic [31:0]                   dbus_addr,
  output logic                          dbus_read,
  output logic                          dbus_write,
  output logic [3:0]                    dbus_be,
  output logic [31:0]                   dbus_wdata,
  input  wire logic [31:0]              dbus_rdata,
  input  wire logic                     dbus_wait
);
  import lsma_pkg::*;

  // ==========================================================================
  // Address forming
  // ==========================================================================
  localparam int          EFF_AW = (BYPASS31 && ADDR_W > LSMA_BYP_AW) ? LSMA_BYP_AW : ADDR_W;
  localparam logic [31:0] AMASK  = (EFF_AW >= LSMA_FULL_AW) ? ~LSMA_ZERO
                                   : ((32'h1 << EFF_AW) - 32'h1);
  localparam int          LINE_W = LSMA_DW + LSMA_FULL_AW;

  lsma_state_t      state_reg;
  lsma_op_t         op_reg;
  logic [31:0]      addr_reg;
  logic             unc_reg;
  logic [31:0]      wdata_reg;
  logic             resp_valid_reg;
  logic [31:0]      resp_data_reg;
  logic [2**IDX_W-1:0] valid_reg;

  logic [31:0]      eff_raw;
  logic [31:0]      eff;
  logic             unc;
  logic             accept;
  logic             cached_load;
  logic [IDX_W-1:0] req_idx;
  logic [IDX_W-1:0] cur_idx;
  logic [LINE_W-1:0] ram_rdata;
  logic             hit;
  logic             bus_done;
  logic             fill;

  assign eff_raw = req_base + {{(32-LSMA_IMM_W){req_imm[15]}}, req_imm};   // [R8]
  assign eff     = eff_raw & AMASK;                                         // [R1] [R2] [R9]
  assign unc     = req_op.io || !HAS_CACHE
                   || (BYPASS31 && eff_raw[LSMA_BYP_BIT]);                  // [R9] [R16]
  assign req_ready   = (state_reg == LSMA_ST_IDLE);
  assign accept      = ce && req_valid && req_ready;
  assign cached_load = !req_op.store && (req_op.cmo == LSMA_CMO_NONE) && !unc;
  assign req_idx     = eff[IDX_W+LSMA_LANE_W-1:LSMA_LANE_W];
  assign cur_idx     = addr_reg[IDX_W+LSMA_LANE_W-1:LSMA_LANE_W];

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign hit      = valid_reg[cur_idx]
                    && (ram_rdata[LINE_W-1:LSMA_DW] == {addr_reg[31:LSMA_LANE_W], LSMA_LANE0});
  assign bus_done = ce && (state_reg == LSMA_ST_BUS) && !dbus_wait;
  assign fill     = bus_done && !op_reg.store && !unc_reg;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= LSMA_ST_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        LSMA_ST_IDLE: begin
          if (accept && req_op.cmo == LSMA_CMO_NONE) begin
            state_reg <= cached_load ? LSMA_ST_LOOK : LSMA_ST_BUS;        // [R12] [R16]
          end
        end
        LSMA_ST_LOOK: begin
          state_reg <= hit ? LSMA_ST_IDLE : LSMA_ST_BUS;                   // [R11]
        end
        LSMA_ST_BUS: begin
          if (!dbus_wait) begin
            state_reg <= LSMA_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_reg    <= '0;
      addr_reg  <= LSMA_ZERO;
      unc_reg   <= 1'b0;
      wdata_reg <= LSMA_ZERO;
    end else if (accept) begin
      op_reg   <= req_op;
      addr_reg <= eff;
      unc_reg  <= unc;
      unique case (req_op.size)                                            // [R15] [R7]
        LSMA_SZ_BYTE: wdata_reg <= {4{req_wdata[7:0]}};
        LSMA_SZ_HALF: wdata_reg <= {2{req_wdata[15:0]}};
        default:      wdata_reg <= req_wdata;
      endcase
    end
  end

  // ==========================================================================
  // Data bus master
  // ==========================================================================
  assign dbus_read  = (state_reg == LSMA_ST_BUS) && !op_reg.store;         // [R5] [R3]
  assign dbus_write = (state_reg == LSMA_ST_BUS) && op_reg.store;          // [R12]
  assign dbus_addr  = {addr_reg[31:LSMA_LANE_W], LSMA_LANE0};
  assign dbus_wdata = wdata_reg;
  assign dbus_be    = lsma_be(op_reg.size, addr_reg[LSMA_LANE_W-1:0]);     // [R6] [R7] [R15]

  // ==========================================================================
  // Load answer
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= LSMA_ZERO;
    end else if (ce) begin
      resp_valid_reg <= 1'b0;
      if (state_reg == LSMA_ST_LOOK && hit) begin
        resp_valid_reg <= 1'b1;
        resp_data_reg  <= lsma_ext(op_reg.size, op_reg.uns,
                                   addr_reg[LSMA_LANE_W-1:0],
                                   ram_rdata[LSMA_DW-1:0]);                // [R13] [R14]
      end else if (bus_done && !op_reg.store) begin
        resp_valid_reg <= 1'b1;
        resp_data_reg  <= lsma_ext(op_reg.size, op_reg.uns,
                                   addr_reg[LSMA_LANE_W-1:0], dbus_rdata); // [R13] [R14] [R4]
      end
    end
  end

  assign resp_valid = resp_valid_reg;
  assign resp_data  = resp_data_reg;

  // ==========================================================================
  // Cache line valid bits and maintenance
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      valid_reg <= '0;
    end else if (ce && HAS_CACHE) begin                                    // [R10]
      if (accept) begin
        unique case (req_op.cmo)                                           // [R17]
          LSMA_CMO_INIT_LINE,
          LSMA_CMO_FLUSH_LINE: valid_reg[req_idx] <= 1'b0;
          LSMA_CMO_FLUSH_ALL:  valid_reg <= '0;
          LSMA_CMO_NONE: begin
            // Write-through: drop any copy a store would make stale
            if (req_op.store) begin
              valid_reg[req_idx] <= 1'b0;
            end
          end
        endcase
      end else if (fill) begin
        valid_reg[cur_idx] <= 1'b1;                                        // [R11]
      end
    end
  end

  lsma_line_ram #(
    .W     (LINE_W),
    .IDX_W (IDX_W)
  ) u_line_ram (
    .mclk  (mclk),
    .ce    (ce),
    .we    (fill),
    .waddr (cur_idx),
    .wdata ({addr_reg[31:LSMA_LANE_W], LSMA_LANE0, dbus_rdata}),
    .re    (accept && cached_load),
    .raddr (req_idx),
    .rdata (ram_rdata)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic acc_io_load;
  logic acc_store;
  logic acc_cmo;
  assign acc_io_load = accept && req_op.cmo == LSMA_CMO_NONE && !req_op.store && req_op.io;
  assign acc_store   = accept && req_op.cmo == LSMA_CMO_NONE && req_op.store;
  assign acc_cmo     = accept && req_op.cmo != LSMA_CMO_NONE;

  AST_ONE_CYCLE_KIND: assert property (@(posedge mclk) disable iff (!rst_b)  // [R12]
    !(dbus_read && dbus_write))
    else $error("read and write strobes together");

  AST_BUS_HELD: assert property (@(posedge mclk) disable iff (!rst_b)  // [R12]
    (dbus_read || dbus_write) && dbus_wait |=>
      (dbus_read || dbus_write) && $stable(dbus_addr) && $stable(dbus_be))
    else $error("bus cycle dropped or changed while stalled");

  AST_IO_LOAD_ON_BUS: assert property (@(posedge mclk) disable iff (!rst_b)  // [R12] [R16]
    acc_io_load |=> dbus_read)
    else $error("peripheral load did not go to the bus");

  AST_STORE_ON_BUS: assert property (@(posedge mclk) disable iff (!rst_b)  // [R12]
    acc_store |=> dbus_write)
    else $error("store was not issued on the bus");

  AST_EFF_ADDR: assert property (@(posedge mclk) disable iff (!rst_b)  // [R8]
    acc_store |=> dbus_addr[31:LSMA_LANE_W] ==
      ((($past(req_base) + {{16{$past(req_imm[15])}}, $past(req_imm)}) & AMASK)
        >> LSMA_LANE_W))
    else $error("effective address is not base plus immediate");

  AST_ADDR_LIMIT: assert property (@(posedge mclk) disable iff (!rst_b)  // [R2] [R9]
    (dbus_read || dbus_write) |-> (dbus_addr & ~AMASK) == LSMA_ZERO)
    else $error("address bit above the usable width driven");

  AST_SIGN_EXT: assert property (@(posedge mclk) disable iff (!rst_b)  // [R13]
    resp_valid && !op_reg.uns && op_reg.size == LSMA_SZ_BYTE |->
      resp_data[31:8] == {24{resp_data[7]}})
    else $error("signed byte load not sign-extended");

  AST_ZERO_EXT: assert property (@(posedge mclk) disable iff (!rst_b)  // [R14]
    resp_valid && op_reg.uns && op_reg.size == LSMA_SZ_HALF |->
      resp_data[31:16] == 16'h0000)
    else $error("unsigned half load not zero-extended");

  AST_NARROW_LANES: assert property (@(posedge mclk) disable iff (!rst_b)  // [R15] [R6]
    dbus_write && op_reg.size == LSMA_SZ_BYTE |-> $onehot(dbus_be))
    else $error("byte store enables more than one lane");

  AST_CMO_NOP: assert property (@(posedge mclk) disable iff (!rst_b)  // [R10]
    acc_cmo |=> !dbus_read && !dbus_write && req_ready && (HAS_CACHE || valid_reg == '0))
    else $error("cache operation had an effect without a cache");

  AST_FLUSH_ALL: assert property (@(posedge mclk) disable iff (!rst_b)  // [R17]
    acc_cmo && req_op.cmo == LSMA_CMO_FLUSH_ALL && HAS_CACHE |=> valid_reg == '0)
    else $error("flush of all lines left a valid line");

  AST_HIT_NO_BUS: assert property (@(posedge mclk) disable iff (!rst_b)  // [R11]
    state_reg == LSMA_ST_LOOK && hit && ce |=> !dbus_read && !dbus_write)
    else $error("cache hit still went to the bus");

  COV_HIT: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == LSMA_ST_LOOK && hit && ce);
  COV_IO_LOAD: cover property (@(posedge mclk) disable iff (!rst_b)
    acc_io_load ##[1:8] resp_valid);
  COV_STORE: cover property (@(posedge mclk) disable iff (!rst_b)
    acc_store ##1 dbus_write && !dbus_wait);
  COV_FLUSH: cover property (@(posedge mclk) disable iff (!rst_b)
    accept && req_op.cmo == LSMA_CMO_FLUSH_ALL);

endmodule : lsma_unit

/* tb/lsma_mem_model.sv */
// Behavioural data-bus memory with programmable stall
`timescale 1ns/1ps
module lsma_mem_model (
  // Clock
  input  wire logic        mclk,
  // Data bus
  input  wire logic [31:0] dbus_addr,
  input  wire logic        dbus_read,
  input  wire logic        dbus_write,
  input  wire logic [3:0]  dbus_be,
  input  wire logic [31:0] dbus_wdata,
  output logic      [31:0] dbus_rdata,
  output logic             dbus_wait,
  // Bench control and status
  input  wire logic [31:0] stall,
  output int               n_done,
  output logic      [31:0] last_addr
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] held;
  logic [31:0] w;
  int          cnt;

  function automatic logic [31:0] rd(input logic [31:0] a);
    rd = mem.exists(a[31:2]) ? mem[a[31:2]] : 32'h0000_0000;
  endfunction : rd

  initial begin
    n_done = 0;
    cnt = 0;
    held = 32'h0000_0000;
    last_addr = 32'h0000_0000;
  end

  assign dbus_wait = (dbus_read || dbus_write) && (cnt < stall);

  // Data only while a read completes, else a changing pattern
  always @(dbus_addr or dbus_read or dbus_wait or held) begin
    if (dbus_read && !dbus_wait) dbus_rdata = rd(dbus_addr);
    else dbus_rdata = ~held;
  end

  always @(posedge mclk) begin
    if (dbus_read || dbus_write) begin
      if (cnt < stall) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        n_done <= n_done + 1;
        last_addr <= dbus_addr;
        if (dbus_read) held <= dbus_rdata;
        if (dbus_write) begin
          w = rd(dbus_addr);
          for (int b = 0; b < 4; b++) if (dbus_be[b]) w[8*b+:8] = dbus_wdata[8*b+:8];
          mem[dbus_addr[31:2]] = w;
        end
      end
    end
  end
endmodule : lsma_mem_model

/* tb/tb.sv */
// Self-checking bench of the load/store access unit
`timescale 1ns/1ps
module tb;
  import lsma_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        req_valid = 1'b0;
  lsma_op_t    req_op = '0;
  logic [31:0] req_base = 32'h0000_0000;
  logic [15:0] req_imm = 16'h0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic        req_ready, resp_valid, dbus_read, dbus_write, dbus_wait;
  logic [31:0] resp_data, dbus_addr, dbus_wdata, dbus_rdata, last_addr, d;
  logic [3:0]  dbus_be;
  int          stall = 0;
  int          n_done, n0;
  int          err_total = 0;
  int          n_checks = 0;

  always #2 mclk = ~mclk;

  lsma_unit i_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_base(req_base), .req_imm(req_imm),
    .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_data(resp_data),
    .dbus_addr(dbus_addr), .dbus_read(dbus_read), .dbus_write(dbus_write),
    .dbus_be(dbus_be), .dbus_wdata(dbus_wdata), .dbus_rdata(dbus_rdata),
    .dbus_wait(dbus_wait));

  lsma_mem_model i_mem (.mclk(mclk), .dbus_addr(dbus_addr), .dbus_read(dbus_read),
    .dbus_write(dbus_write), .dbus_be(dbus_be), .dbus_wdata(dbus_wdata),
    .dbus_rdata(dbus_rdata), .dbus_wait(dbus_wait), .stall(stall), .n_done(n_done),
    .last_addr(last_addr));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic lsma_op_t op(input bit st, input bit io, input bit uns,
                                  input lsma_size_t sz, input lsma_cmo_t cm = LSMA_CMO_NONE);
    op = '{store: st, io: io, uns: uns, size: sz, cmo: cm};
  endfunction : op

  function automatic logic [31:0] ext(input logic [31:0] w, input int k, input bit h,
                                      input bit u);
    logic [31:0] s;
    s = w >> (8 * k);
    if (h) ext = u ? {16'h0000, s[15:0]} : {{16{s[15]}}, s[15:0]};
    else ext = u ? {24'h00_0000, s[7:0]} : {{24{s[7]}}, s[7:0]};
  endfunction : ext

  // Bounded wait for the unit to accept again
  task automatic wait_ready();
    int i;
    i = 0;
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
      if (++i > 60) begin
        err_total++;
        conclude();
      end
    end
  endtask : wait_ready

  task automatic issue(input lsma_op_t o, input logic [31:0] b, input logic [15:0] im,
                       input logic [31:0] wd);
    wait_ready();
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= o;
    req_base <= b;
    req_imm <= im;
    req_wdata <= wd;
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask : issue

  task automatic load(input lsma_op_t o, input logic [31:0] b, input logic [15:0] im,
                      output logic [31:0] r);
    int i;
    issue(o, b, im, 32'h0000_0000);
    i = 0;
    #1;
    while (resp_valid !== 1'b1) begin
      @(posedge mclk);
      #1;
      if (++i > 60) begin
        err_total++;
        conclude();
      end
    end
    r = resp_data;
  endtask : load

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_endian();
    logic [31:0] w;
    w = 32'h8877_6655;
    issue(op(1, 1, 0, LSMA_SZ_WORD), 32'h0000_1010, 16'hFFF0, w);
    load(op(0, 1, 0, LSMA_SZ_WORD), 32'h0000_1000, 16'h0000, d);
    chk("word load", d, w);
    for (int k = 0; k < 4; k++) begin
      for (int u = 0; u < 2; u++) begin
        load(op(0, 1, u[0], LSMA_SZ_BYTE), 32'h0000_1010, 16'hFFF0 + 16'(k), d);
        chk("byte load", d, ext(w, k, 1'b0, u[0]));
        if (k % 2 == 0) begin
          load(op(0, 1, u[0], LSMA_SZ_HALF), 32'h0000_1010, 16'hFFF0 + 16'(k), d);
          chk("half load", d, ext(w, k, 1'b1, u[0]));
        end
      end
    end
  endtask : s_endian

  task automatic s_narrow();
    stall = 2;
    n0 = n_done;
    issue(op(1, 1, 0, LSMA_SZ_BYTE), 32'h0000_1000, 16'h0001, 32'hAABB_CCDD);
    issue(op(1, 1, 0, LSMA_SZ_HALF), 32'h0000_1000, 16'h0002, 32'h1234_5678);
    load(op(0, 1, 0, LSMA_SZ_WORD), 32'h0000_1000, 16'h0000, d);
    chk("narrow stores", d, 32'h5678_DD55);
    chk("narrow io cycles", 32'(n_done - n0), 32'h0000_0003);
  endtask : s_narrow

  task automatic s_order();
    stall = 3;
    n0 = n_done;
    issue(op(1, 1, 0, LSMA_SZ_WORD), 32'h0000_3000, 16'h0000, 32'h1111_2222);
    issue(op(1, 1, 0, LSMA_SZ_WORD), 32'h0000_3000, 16'h0000, 32'h3333_4444);
    load(op(0, 1, 0, LSMA_SZ_WORD), 32'h0000_3000, 16'h0000, d);
    chk("io order", d, 32'h3333_4444);
    chk("io cycles", 32'(n_done - n0), 32'h0000_0003);
  endtask : s_order

  task automatic s_cache();
    lsma_cmo_t cm[3] = '{LSMA_CMO_INIT_LINE, LSMA_CMO_FLUSH_LINE, LSMA_CMO_FLUSH_ALL};
    stall = 1;
    issue(op(1, 1, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, 32'hCAFE_F00D);
    wait_ready();
    n0 = n_done;
    load(op(0, 0, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, d);
    chk("miss data", d, 32'hCAFE_F00D);
    load(op(0, 0, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, d);
    chk("hit data", d, 32'hCAFE_F00D);
    chk("hit cycles", 32'(n_done - n0), 32'h0000_0001);
    foreach (cm[j]) begin
      issue(op(0, 0, 0, LSMA_SZ_WORD, cm[j]), 32'h0000_2000, 16'h0000, 32'h0000_0000);
      load(op(0, 0, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, d);
      chk("refill cycles", 32'(n_done - n0), 32'(j + 2));
    end
    issue(op(1, 0, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, 32'h1357_9BDF);
    load(op(0, 1, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, d);
    chk("write through", d, 32'h1357_9BDF);
    load(op(0, 0, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, d);
    chk("no stale hit", d, 32'h1357_9BDF);
  endtask : s_cache

  task automatic s_top();
    stall = 0;
    issue(op(1, 1, 0, LSMA_SZ_WORD), 32'h0000_0004, 16'hFFF8, 32'h0BAD_F00D);
    wait_ready();
    chk("top address", last_addr, 32'hFFFF_FFFC);
    load(op(0, 1, 0, LSMA_SZ_WORD), 32'hFFFF_FF00, 16'h00FC, d);
    chk("top data", d, 32'h0BAD_F00D);
  endtask : s_top

  // Clock enable low holds a pending peripheral read
  task automatic s_freeze();
    stall = 0;
    issue(op(0, 1, 0, LSMA_SZ_WORD), 32'h0000_3000, 16'h0000, 32'h0000_0000);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("frozen read", {31'h0000_0000, dbus_read}, 32'h0000_0001);
    chk("frozen answer", {31'h0000_0000, resp_valid}, 32'h0000_0000);
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    #1;
    chk("thawed answer", {31'h0000_0000, resp_valid}, 32'h0000_0001);
    chk("thawed data", resp_data, 32'h3333_4444);
  endtask : s_freeze

  // Mid-run reset empties the cache
  task automatic s_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    n0 = n_done;
    load(op(0, 0, 0, LSMA_SZ_WORD), 32'h0000_2000, 16'h0000, d);
    chk("reset refill data", d, 32'h1357_9BDF);
    chk("reset refill cycles", 32'(n_done - n0), 32'h0000_0001);
  endtask : s_reset

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (4) @(posedge mclk);
    chk("ready in reset", {31'h0000_0000, req_ready}, 32'h0000_0001);
    rst_b <= 1'b1;
    s_endian();
    s_narrow();
    s_order();
    s_cache();
    s_top();
    s_freeze();
    s_reset();
    conclude();
  end
endmodule : tb
